// File: rtl/bcfp_regs.vh
/*
 * Constants for the bidirectional clocked FIFO port control: queue geometry,
 * flag thresholds, offset defaults and the reset and flag pipeline depths.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef BCFP_REGS_VH
`define BCFP_REGS_VH

// ------------------------------------------------------------------
// queue geometry
// ------------------------------------------------------------------
`define BCFP_DEPTH          512
`define BCFP_WIDTH          18
`define BCFP_ADDR_W         9
`define BCFP_CNT_W          10

// ------------------------------------------------------------------
// flag thresholds and offset programming
// ------------------------------------------------------------------
`define BCFP_HALF_LEVEL     10'h100
`define BCFP_FULL_LEVEL     10'h200
`define BCFP_OFF_W          8
`define BCFP_OFF_LSB        0
`define BCFP_OFF_DEFAULT    8'h80

// ------------------------------------------------------------------
// timing counts, in port clock edges
// ------------------------------------------------------------------
`define BCFP_RESET_EDGES    3'h4
`define BCFP_IR_EDGES       2
`define BCFP_OR_EDGES       3

`endif

// File: rtl/bcfp_ram.v
/*
 * Word storage for one queue: flip-flop array with one write index and one
 * combinational read index.
 * Assumes the caller never writes a full array and owns all pointer logic.
 */
`timescale 1ns/10ps
`default_nettype none

module bcfp_ram #(
	parameter WIDTH  = 18,
	parameter DEPTH  = 512,
	parameter ADDR_W = 9
) (
	input  wire              clk,      // port clock
	input  wire              wr_en,    // store wr_data at wr_idx
	input  wire [ADDR_W-1:0] wr_idx,   // write index
	input  wire [WIDTH-1:0]  wr_data,  // word to store
	input  wire [ADDR_W-1:0] rd_idx,   // read index
	output wire [WIDTH-1:0]  rd_data   // word at rd_idx
);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	// no reset on the array: contents are only visible after a write
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	assign rd_data = mem_q[rd_idx];

endmodule // bcfp_ram

`default_nettype wire

// File: rtl/bcfp_port_ctrl.v
/*
 * Port control for a bidirectional clocked FIFO: two queues of 512 x 18
 * running in opposite directions, port A writes the forward queue and reads
 * the reverse queue, port B the other way round. Holds the top module and
 * the per-queue control; word storage lives in bcfp_ram.
 * Assumes one clock for both ports and inputs synchronous to it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bcfp_regs.vh"

// ----------------------------------------------------------------------
// one queue: pointers, fall-through, flags, offsets
// ----------------------------------------------------------------------
module bcfp_queue #(
	parameter WIDTH  = `BCFP_WIDTH,
	parameter DEPTH  = `BCFP_DEPTH,
	parameter ADDR_W = `BCFP_ADDR_W,
	parameter CNT_W  = `BCFP_CNT_W
) (
	input  wire             clk,           // port clock
	input  wire             rst_n,         // synchronised system reset
	input  wire             qreset_n,      // queue reset, low active
	input  wire             wr_req,        // qualified write
	input  wire [WIDTH-1:0] wr_data,       // word from writing port
	input  wire             prog_n,        // offset program enable, low active
	input  wire             rd_req,        // qualified read
	output reg              ir_q,          // input ready
	output reg              or_q,          // output ready
	output reg  [WIDTH-1:0] dout_q,        // output register
	output reg              afe_q,         // almost full or empty
	output reg              hf_q,          // half full
	output reg  [2:0]       rst_edges_q    // edges seen with reset low, saturating
);

	reg  [CNT_W-1:0]        wr_ptr_q;
	reg  [CNT_W-1:0]        rd_ptr_q;
	reg                     rel_q;
	reg  [1:0]              ne_q;
	reg                     prog_ok_q;
	reg  [1:0]              prog_edge_q;
	reg  [`BCFP_OFF_W-1:0]  off_x_q;
	reg  [`BCFP_OFF_W-1:0]  off_y_q;
	wire [WIDTH-1:0]        ram_rd;
	wire [CNT_W-1:0]        level;
	wire                    prog_edge;
	wire                    do_wr;
	wire                    do_load;
	wire                    do_drop;
	wire [CNT_W-1:0]        wr_ptr_d;
	wire [CNT_W-1:0]        rd_ptr_d;
	wire                    or_d;
	wire [CNT_W-1:0]        total_d;
	wire [CNT_W-1:0]        full_lvl;

	assign level    = wr_ptr_q - rd_ptr_q;
	// programming only inside the window between reset and first write
	assign prog_edge = !prog_n && prog_ok_q;
	// a programming edge never stores a word
	assign do_wr    = wr_req && prog_n;
	// first word waits for the two-stage empty sync, later words stream
	assign do_load  = (level != {CNT_W{1'b0}}) && (or_q ? rd_req : ne_q[1]);
	assign do_drop  = or_q && rd_req && (level == {CNT_W{1'b0}});
	assign wr_ptr_d = do_wr ? wr_ptr_q + {{(CNT_W-1){1'b0}}, 1'b1} : wr_ptr_q;
	assign rd_ptr_d = do_load ? rd_ptr_q + {{(CNT_W-1){1'b0}}, 1'b1} : rd_ptr_q;
	assign or_d     = do_load ? 1'b1 : (do_drop ? 1'b0 : or_q);
	// the output register counts as a stored word
	assign total_d  = (wr_ptr_d - rd_ptr_d) + {{(CNT_W-1){1'b0}}, or_d};
	assign full_lvl = `BCFP_FULL_LEVEL;

	bcfp_ram #(
		.WIDTH  (WIDTH),
		.DEPTH  (DEPTH),
		.ADDR_W (ADDR_W)
	) u_ram (
		.clk     (clk),
		.wr_en   (do_wr),
		.wr_idx  (wr_ptr_q[ADDR_W-1:0]),
		.wr_data (wr_data),
		.rd_idx  (rd_ptr_q[ADDR_W-1:0]),
		.rd_data (ram_rd)
	);

	// ------------------------------------------------------------------
	// pointers, ready flags and output register
	// ------------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q    <= {CNT_W{1'b0}};
			rd_ptr_q    <= {CNT_W{1'b0}};
			rel_q       <= 1'b0;
			ne_q        <= 2'h0;
			ir_q        <= 1'b0;
			or_q        <= 1'b0;
			dout_q      <= {WIDTH{1'b0}};
			afe_q       <= 1'b1;
			hf_q        <= 1'b0;
			rst_edges_q <= 3'h0;
		end else if (!qreset_n) begin
			// reset acts at once; four edges are what the far side owes
			wr_ptr_q    <= {CNT_W{1'b0}};
			rd_ptr_q    <= {CNT_W{1'b0}};
			rel_q       <= 1'b0;
			ne_q        <= 2'h0;
			ir_q        <= 1'b0;
			or_q        <= 1'b0;
			afe_q       <= 1'b1;
			hf_q        <= 1'b0;
			if (rst_edges_q != `BCFP_RESET_EDGES) begin
				rst_edges_q <= rst_edges_q + 3'h1;
			end
		end else begin
			rst_edges_q <= 3'h0;
			wr_ptr_q    <= wr_ptr_d;
			rd_ptr_q    <= rd_ptr_d;
			// rel_q at the first edge after release, ready at the second
			rel_q       <= 1'b1;
			ir_q        <= rel_q && (total_d != full_lvl);
			ne_q        <= {ne_q[0], (level != {CNT_W{1'b0}})};
			or_q        <= or_d;
			if (do_load) begin
				dout_q <= ram_rd;
			end
			// last word stays on the outputs after the queue drains
			afe_q <= (total_d <= {2'h0, off_x_q}) ||
				(total_d >= full_lvl - {2'h0, off_y_q});
			hf_q  <= (total_d >= `BCFP_HALF_LEVEL);
		end
	end

	// ------------------------------------------------------------------
	// offset programming
	// ------------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_ok_q   <= 1'b1;
			prog_edge_q <= 2'h0;
			off_x_q     <= `BCFP_OFF_DEFAULT;
			off_y_q     <= `BCFP_OFF_DEFAULT;
		end else if (!qreset_n) begin
			prog_ok_q   <= 1'b1;
			prog_edge_q <= 2'h0;
		end else begin
			if (do_wr) begin
				prog_ok_q <= 1'b0;
			end
			if (prog_n) begin
				prog_edge_q <= 2'h0;
			end else if (prog_edge && prog_edge_q != 2'h2) begin
				prog_edge_q <= prog_edge_q + 2'h1;
			end
			// 8-bit unsigned field, so 0 to 255 with nothing to clamp
			if (prog_edge && prog_edge_q == 2'h0) begin
				off_x_q <= wr_data[`BCFP_OFF_LSB +: `BCFP_OFF_W];
				off_y_q <= wr_data[`BCFP_OFF_LSB +: `BCFP_OFF_W];
			end else if (prog_edge && prog_edge_q == 2'h1) begin
				off_y_q <= wr_data[`BCFP_OFF_LSB +: `BCFP_OFF_W];
			end
		end
	end

endmodule // bcfp_queue

// ----------------------------------------------------------------------
// top: two ports, two queues
// ----------------------------------------------------------------------
module bcfp_port_ctrl #(
	parameter WIDTH = `BCFP_WIDTH,
	parameter DEPTH = `BCFP_DEPTH
) (
	input  wire             sys_clk,              // clock of both ports
	input  wire             reset_n,              // system reset, low active
	input  wire [WIDTH-1:0] a_data_in,            // port A data lines, input
	output wire [WIDTH-1:0] a_data_out,           // port A data lines, output
	output reg              a_data_oe_n,          // port A drive, low drives
	input  wire             a_port_write_enable,  // port A write enable
	input  wire             a_port_read_enable,   // port A read enable
	input  wire             a_write_read_select,  // port A high write, low read
	input  wire             a_port_chip_select_n, // port A chip select
	input  wire             a_offset_program_enable_n, // forward offsets
	input  wire             fwd_queue_reset_n,    // forward queue reset
	output wire             a_input_ready_flag,   // forward queue not full
	output wire             a_output_ready_flag,  // reverse queue word ready
	output wire             a_almost_full_empty_flag, // forward almost flag
	output wire             a_half_full_flag,     // forward half full
	input  wire [WIDTH-1:0] b_data_in,            // port B data lines, input
	output wire [WIDTH-1:0] b_data_out,           // port B data lines, output
	output reg              b_data_oe_n,          // port B drive, low drives
	input  wire             b_port_write_enable,  // port B write enable
	input  wire             b_port_read_enable,   // port B read enable
	input  wire             b_write_read_select,  // port B high write, low read
	input  wire             b_port_chip_select_n, // port B chip select
	input  wire             b_offset_program_enable_n, // reverse offsets
	input  wire             rev_queue_reset_n,    // reverse queue reset
	output wire             b_input_ready_flag,   // reverse queue not full
	output wire             b_output_ready_flag,  // forward queue word ready
	output wire             b_almost_full_empty_flag, // reverse almost flag
	output wire             b_half_full_flag      // reverse half full
);

	reg  [1:0] rst_sync_q;
	wire       rst_n_s;
	wire       a_wr;
	wire       a_rd;
	wire       b_wr;
	wire       b_rd;

	// ------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_s = rst_sync_q[1];

	// ------------------------------------------------------------------
	// port qualification
	// ------------------------------------------------------------------
	assign a_wr = a_port_write_enable && a_write_read_select &&
		!a_port_chip_select_n && a_input_ready_flag;
	assign a_rd = !a_write_read_select && a_port_read_enable &&
		!a_port_chip_select_n && a_output_ready_flag;
	assign b_wr = b_port_write_enable && b_write_read_select &&
		!b_port_chip_select_n && b_input_ready_flag;
	assign b_rd = !b_write_read_select && b_port_read_enable &&
		!b_port_chip_select_n && b_output_ready_flag;

	// registered enable costs one cycle of turn-around on the lines
	always @(posedge sys_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			a_data_oe_n <= 1'b1;
			b_data_oe_n <= 1'b1;
		end else begin
			a_data_oe_n <= a_write_read_select || a_port_chip_select_n;
			b_data_oe_n <= b_write_read_select || b_port_chip_select_n;
		end
	end

	// ------------------------------------------------------------------
	// queues
	// ------------------------------------------------------------------
	bcfp_queue #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fwd_queue (
		.clk         (sys_clk),
		.rst_n       (rst_n_s),
		.qreset_n    (fwd_queue_reset_n),
		.wr_req      (a_wr),
		.wr_data     (a_data_in),
		.prog_n      (a_offset_program_enable_n),
		.rd_req      (b_rd),
		.ir_q        (a_input_ready_flag),
		.or_q        (b_output_ready_flag),
		.dout_q      (b_data_out),
		.afe_q       (a_almost_full_empty_flag),
		.hf_q        (a_half_full_flag),
		.rst_edges_q ()
	);

	bcfp_queue #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_rev_queue (
		.clk         (sys_clk),
		.rst_n       (rst_n_s),
		.qreset_n    (rev_queue_reset_n),
		.wr_req      (b_wr),
		.wr_data     (b_data_in),
		.prog_n      (b_offset_program_enable_n),
		.rd_req      (a_rd),
		.ir_q        (b_input_ready_flag),
		.or_q        (a_output_ready_flag),
		.dout_q      (a_data_out),
		.afe_q       (b_almost_full_empty_flag),
		.hf_q        (b_half_full_flag),
		.rst_edges_q ()
	);

endmodule // bcfp_port_ctrl

`default_nettype wire

// File: rtl/dummy_unused_marker.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: verification/bcfp_host_model.sv
/* host side of one port: resolves the shared data lines.
   assumes dev_oe_n low means the device drives the lines */
`timescale 1ns/10ps
`default_nettype none
module bcfp_host_model (
	input  wire logic        clk,      // port clock
	input  wire logic [17:0] dev_out,  // device output
	input  wire logic        dev_oe_n, // device drive, low drives
	input  wire logic        drv,      // host drives
	input  wire logic [17:0] hdata,    // host word
	output logic      [17:0] line      // resolved level
);
	logic [17:0] last_q;
	// released lines change every cycle, so a stale word never passes
	always_comb line = !dev_oe_n ? dev_out : (drv ? hdata : ~last_q);
	always @(posedge clk) begin
		last_q <= line;
	end
endmodule // bcfp_host_model
`default_nettype wire

// File: verification/bcfp_port_ctrl_chk.sv
/* checker for the port control top: drive, reset, flag and fall-through.
   assumes binding to bcfp_port_ctrl, one clock for both ports */
`timescale 1ns/10ps
`default_nettype none
module bcfp_port_ctrl_chk #(parameter DEPTH = 512) (
	input wire logic sys_clk,                   // clock
	input wire logic reset_n,                   // system reset
	input wire logic a_write_read_select,       // A select
	input wire logic a_port_chip_select_n,      // A chip select
	input wire logic a_port_write_enable,       // A write enable
	input wire logic a_offset_program_enable_n, // A program enable
	input wire logic a_input_ready_flag,        // A ready in
	input wire logic a_output_ready_flag,       // A ready out
	input wire logic a_almost_full_empty_flag,  // A almost flag
	input wire logic a_half_full_flag,          // A half full
	input wire logic a_data_oe_n,               // A drive
	input wire logic fwd_queue_reset_n,         // forward reset
	input wire logic rev_queue_reset_n,         // reverse reset
	input wire logic b_write_read_select,       // B select
	input wire logic b_port_chip_select_n,      // B chip select
	input wire logic b_port_read_enable,        // B read enable
	input wire logic b_input_ready_flag,        // B ready in
	input wire logic b_output_ready_flag,       // B ready out
	input wire logic b_almost_full_empty_flag,  // B almost flag
	input wire logic b_half_full_flag,          // B half full
	input wire logic b_data_oe_n                // B drive
);
	logic [1:0] rel_q;
	logic [9:0] cnt_q;
	wire settled = rel_q == 2'h3;
	wire wr_take = a_port_write_enable & a_write_read_select & ~a_port_chip_select_n
		& a_input_ready_flag & a_offset_program_enable_n;
	wire rd_take = ~b_write_read_select & b_port_read_enable & ~b_port_chip_select_n
		& b_output_ready_flag;
	// forward queue fill, output register included
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rel_q <= 2'h0;
			cnt_q <= 10'h0;
		end else begin
			if (rel_q != 2'h3)
				rel_q <= rel_q + 2'h1;
			if (!fwd_queue_reset_n)
				cnt_q <= 10'h0;
			else
				cnt_q <= cnt_q + {9'h0, wr_take} - {9'h0, rd_take};
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_first_wr;
		settled && cnt_q == 10'h0 && wr_take;
	endsequence
	sequence s_fall;
		!b_output_ready_flag [*3] ##1 b_output_ready_flag;
	endsequence
	sequence s_qrel;
		settled && !fwd_queue_reset_n ##1 fwd_queue_reset_n;
	endsequence
	AST_A_HIZ: assert property (settled && a_write_read_select |=> a_data_oe_n)
		else $error("port A lines driven while select high");
	AST_B_DRIVE: assert property (settled && !b_write_read_select
		&& !b_port_chip_select_n |=> !b_data_oe_n)
		else $error("port B lines not driven on read select");
	AST_QRST_FLAGS: assert property (settled && !fwd_queue_reset_n
		|=> !a_input_ready_flag && !b_output_ready_flag && a_almost_full_empty_flag
		&& !a_half_full_flag)
		else $error("forward reset flags wrong");
	AST_REV_QRST: assert property (settled && !rev_queue_reset_n
		|=> !b_input_ready_flag && !a_output_ready_flag && b_almost_full_empty_flag
		&& !b_half_full_flag)
		else $error("reverse reset flags wrong");
	AST_IR_AFTER_QRST: assert property (s_qrel |=> !a_input_ready_flag ##1 a_input_ready_flag)
		else $error("input ready not on second edge");
	AST_HALF_FULL: assert property (settled |-> a_half_full_flag == (cnt_q >= 10'h100))
		else $error("half full disagrees with fill");
	AST_FULL_STOP: assert property (settled && cnt_q == DEPTH |-> !a_input_ready_flag)
		else $error("input ready high while full");
	AST_EMPTY_NO_OR: assert property (settled && cnt_q == 10'h0 |-> !b_output_ready_flag)
		else $error("output ready high while empty");
	AST_FALL_THROUGH: assert property (s_first_wr |=> s_fall)
		else $error("first word not on third edge");
	AST_PROG_NO_STORE: assert property (settled && cnt_q == 10'h0
		&& !a_offset_program_enable_n && a_port_write_enable && a_write_read_select
		&& !a_port_chip_select_n && a_input_ready_flag |-> ##4 !b_output_ready_flag)
		else $error("word stored on programming edge");
endmodule // bcfp_port_ctrl_chk
bind bcfp_port_ctrl bcfp_port_ctrl_chk #(.DEPTH(DEPTH)) bcfp_port_ctrl_chk_i (
	.sys_clk(sys_clk), .reset_n(reset_n), .a_write_read_select(a_write_read_select),
	.a_port_chip_select_n(a_port_chip_select_n), .a_port_write_enable(a_port_write_enable),
	.a_offset_program_enable_n(a_offset_program_enable_n),
	.a_input_ready_flag(a_input_ready_flag), .a_output_ready_flag(a_output_ready_flag),
	.a_almost_full_empty_flag(a_almost_full_empty_flag), .a_half_full_flag(a_half_full_flag),
	.a_data_oe_n(a_data_oe_n), .fwd_queue_reset_n(fwd_queue_reset_n),
	.rev_queue_reset_n(rev_queue_reset_n), .b_write_read_select(b_write_read_select),
	.b_port_chip_select_n(b_port_chip_select_n), .b_port_read_enable(b_port_read_enable),
	.b_input_ready_flag(b_input_ready_flag), .b_output_ready_flag(b_output_ready_flag),
	.b_almost_full_empty_flag(b_almost_full_empty_flag), .b_half_full_flag(b_half_full_flag),
	.b_data_oe_n(b_data_oe_n)
);
`default_nettype wire

// File: verification/bcfp_port_ctrl_tb_top.sv
/* bench for the port control: host tasks on both ports, word scoreboard.
   assumes the host model, checker and design files are compiled first */
`timescale 1ns/10ps
`default_nettype none
module bcfp_port_ctrl_tb_top;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [1:0]  we = 2'h0, re = 2'h0, sel = 2'h3, csn = 2'h3, pen = 2'h3, qrst = 2'h3, dv = 2'h0;
	logic [17:0] hd [2] = '{18'h0, 18'h0};
	logic [17:0] eq [2][$];
	wire  [17:0] ln [2];
	wire  [17:0] dout [2];
	wire  [1:0]  oen, irf, orf, afe, hf;
	int          fails = 0, comparisons = 0;
	logic [31:0] seed = 32'h6eb2;
	always #50 sys_clk = ~sys_clk;
	bcfp_port_ctrl bcfp_port_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.a_data_in(ln[0]), .a_data_out(dout[0]), .a_data_oe_n(oen[0]),
		.a_port_write_enable(we[0]), .a_port_read_enable(re[0]), .a_write_read_select(sel[0]),
		.a_port_chip_select_n(csn[0]), .a_offset_program_enable_n(pen[0]),
		.fwd_queue_reset_n(qrst[0]), .a_input_ready_flag(irf[0]), .a_output_ready_flag(orf[0]),
		.a_almost_full_empty_flag(afe[0]), .a_half_full_flag(hf[0]),
		.b_data_in(ln[1]), .b_data_out(dout[1]), .b_data_oe_n(oen[1]),
		.b_port_write_enable(we[1]), .b_port_read_enable(re[1]), .b_write_read_select(sel[1]),
		.b_port_chip_select_n(csn[1]), .b_offset_program_enable_n(pen[1]),
		.rev_queue_reset_n(qrst[1]), .b_input_ready_flag(irf[1]), .b_output_ready_flag(orf[1]),
		.b_almost_full_empty_flag(afe[1]), .b_half_full_flag(hf[1]));
	bcfp_host_model host_a (.clk(sys_clk), .dev_out(dout[0]), .dev_oe_n(oen[0]),
		.drv(dv[0]), .hdata(hd[0]), .line(ln[0]));
	bcfp_host_model host_b (.clk(sys_clk), .dev_out(dout[1]), .dev_oe_n(oen[1]),
		.drv(dv[1]), .hdata(hd[1]), .line(ln[1]));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic put(input int p, input logic [17:0] d);
		sel[p] = 1'b1;
		csn[p] = 1'b0;
		re[p] = 1'b0;
		// the drive turns off one cycle late, so never fight it
		if (oen[p] !== 1'b1)
			@(negedge sys_clk);
		we[p] = 1'b1;
		dv[p] = 1'b1;
		hd[p] = d;
		if (irf[p] === 1'b1 && pen[p]) eq[p].push_back(d);
		@(negedge sys_clk);
	endtask
	task automatic get(input int p, input int n);
		we[p] = 1'b0;
		dv[p] = 1'b0;
		sel[p] = 1'b0;
		csn[p] = 1'b0;
		@(negedge sys_clk);
		chk(18'(oen[p]), 18'h0);
		chk(ln[p], dout[p]);
		repeat (n) begin
			re[p] = (rnd() & 32'h3) != 0;
			@(negedge sys_clk);
		end
		re[p] = 1'b0;
		sel[p] = 1'b1;
	endtask
	// scoreboard: each taken read must show the oldest word written
	always @(posedge sys_clk) begin
		for (int r = 0; r < 2; r++) begin
			if (reset_n && !sel[r] && !csn[r] && re[r] && orf[r] === 1'b1) begin
				if (eq[1-r].size() != 0)
					chk(dout[r], eq[1-r].pop_front());
				else
					chk(18'h0, 18'h1);
			end
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#(4000 * 100);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (2) @(negedge sys_clk);
		chk({12'h0, irf, afe, hf}, {12'h0, 2'h0, 2'h3, 2'h0});
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk(18'(irf), 18'h3);
		$display("test reset done");
		sel[0] = 1'b1;
		csn[0] = 1'b0;
		we[0] = 1'b1;
		dv[0] = 1'b1;
		pen[0] = 1'b0;
		hd[0] = 18'h3ff05;
		@(negedge sys_clk);
		hd[0] = 18'h3ffff;
		@(negedge sys_clk);
		pen[0] = 1'b1;
		for (int n = 1; n <= 514; n++) begin
			int k;
			put(0, 18'(rnd()));
			k = (n > 512) ? 512 : n;
			chk({15'h0, irf[0], afe[0], hf[0]}, {15'h0, k < 512, k <= 5 || k >= 257, k >= 256});
			if (n == 2) begin
				pen[0] = 1'b0;
				hd[0] = 18'hc8;
				@(negedge sys_clk);
				pen[0] = 1'b1;
			end
		end
		we[0] = 1'b0;
		$display("test program and fill done");
		get(1, 800);
		chk({14'h0, irf[0], orf[1], afe[0], hf[0]}, {14'h0, 4'ha});
		chk(18'(eq[0].size()), 18'h0);
		qrst[0] = 1'b0;
		repeat (4) @(negedge sys_clk);
		qrst[0] = 1'b1;
		@(negedge sys_clk);
		chk(18'(irf[0]), 18'h0);
		@(negedge sys_clk);
		chk(18'(irf[0]), 18'h1);
		$display("test drain and forward reset done");
		for (int n = 1; n <= 130; n++) begin
			put(1, 18'(rnd()));
			chk({16'h0, afe[1], hf[1]}, {16'h0, n <= 128, 1'b0});
		end
		we[1] = 1'b0;
		get(0, 20);
		qrst[1] = 1'b0;
		eq[1].delete();
		repeat (4) @(negedge sys_clk);
		chk({14'h0, irf[1], orf[0], afe[1], hf[1]}, {14'h0, 4'h2});
		qrst[1] = 1'b1;
		repeat (3) @(negedge sys_clk);
		for (int n = 0; n < 3; n++)
			put(1, 18'(rnd()));
		we[1] = 1'b0;
		get(0, 16);
		chk(18'(eq[1].size()), 18'h0);
		$display("test reverse queue done");
		end_of_test();
	end
endmodule // bcfp_port_ctrl_tb_top
`default_nettype wire
